// ---- hw/sar_adc_conversion_control.sv ----
/*
  successive approximation converter sequencer with Avalon-MM registers.
  assumes comparator, rc tick, sleep and trigger inputs synchronous to clock.
*/
// Register access over Avalon-MM and the address map are this design's own decisions.
`timescale 1ns/1ps
module sar_adc_conversion_control
  import sar_ctrl_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1, // inputs 8..11 exist
  parameter int DELAY_CLKS = INSTR_CLKS // one instruction, in clocks
) (
  input wire logic clock, // 50 MHz system clock
  input wire logic rst, // synchronous reset, high
  input wire logic [4:0] address, // byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [3:0] byteenable, // lane 0 carries the register
  input wire logic [31:0] writedata, // write data
  output logic [31:0] readdata, // read data
  output logic waitrequest, // high until answer
  input wire logic compareHigh, // sampled input at or above dac trial
  input wire logic rcTick, // half period pulse of rc oscillator
  input wire logic sleepMode, // core is in sleep
  input wire logic specialTrigger, // event pulse from compare unit four
  output logic [9:0] dacCode, // trial code to the capacitor dac
  output logic sampleHold, // high while sampler holds input
  output logic converterPower, // analog bias on
  output logic [4:0] channelSelect, // mux code
  output logic channelConnected, // mux code reaches an input
  output logic negRefSelect, // 1 selects external negative pin
  output logic [1:0] posRefSelect, // positive reference code
  output logic wakeRequest, // pulse: wake core
  output logic timerReset, // pulse: clear timer one counter
  output logic doneFlag // conversion done flag
);
  // ==========================================================
  // registers and state
  control_t control; // go bit here mirrors busy
  config_t settings; // format, clock, references
  logic [7:0] resHigh; // result_high_byte
  logic [7:0] resLow; // result_low_byte
  logic irqEnable; // conversion_irq_enable
  logic sleepOff; // converter parked by sleep
  state_t state; // sequencer state
  logic [9:0] sar; // approximation register
  logic [3:0] bitIdx; // bit under trial
  logic lastBit; // last resolved bit value
  logic anyResolved; // at least one bit resolved
  logic [4:0] halfCnt; // half periods elapsed
  logic [5:0] divCnt; // system clock divider
  logic [7:0] delayCnt; // extra instruction delay
  logic halfTick; // one half period elapsed
  logic busAck; // request answered this cycle
  logic regWrite; // write takes effect
  logic isRc; // rc clock selected
  logic startReq; // software or trigger start
  logic abortReq; // software clears go, or converter enable is low
  logic sleepAbort; // sleep kills non-rc conversion
  logic finish; // last half period of conversion
  logic [5:0] halfLen; // clocks per half period
  logic [15:0] next_result; // formatted bytes
  logic [9:0] partial; // aborted value, filled

  // ==========================================================
  // decode helpers
  assign busAck = (read | write) & ~waitrequest;
  assign regWrite = write & busAck & byteenable[0];
  assign isRc = (settings.convClockSelect[1:0] == CLK_RC_LOW);
  assign startReq = (state == ST_IDLE) & control.converterEnable &
    ((regWrite & address == OFF_CONTROL & writedata[1]) | specialTrigger);
  assign abortReq = (state != ST_IDLE) & ((regWrite &
    address == OFF_CONTROL & ~writedata[1]) | ~control.converterEnable);
  assign sleepAbort = (state != ST_IDLE) & sleepMode & ~isRc;
  assign finish = (state == ST_CONV) & halfTick &
    (halfCnt == CONV_HALF_TADS - 5'd1);

  // half period length in system clocks per divider code
  always_comb begin
    unique case (settings.convClockSelect)
      3'b000: halfLen = 6'd1;
      3'b100: halfLen = 6'd2;
      3'b001: halfLen = 6'd4;
      3'b101: halfLen = 6'd8;
      3'b010: halfLen = 6'd16;
      3'b110: halfLen = 6'd32;
      default: halfLen = 6'd1;
    endcase
  end
  assign halfTick = isRc ? rcTick : (divCnt == halfLen - 6'd1);

  // unresolved bits copy the last resolved bit, zero if none
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      if (i > int'(bitIdx) || bitIdx > 4'd9) begin // wrapped: all done
        partial[i] = sar[i];
      end else begin
        partial[i] = anyResolved & lastBit;
      end
    end
  end

  // format of the loaded value
  always_comb begin
    logic [9:0] v;
    v = finish ? sar : partial; // bit 0 was decided one tick earlier
    if (settings.resultJustifySelect) begin
      next_result = {6'h00, v[9:8], v[7:0]};
    end else begin
      next_result = {v[9:2], v[1:0], 6'h00};
    end
  end

  // ==========================================================
  // avalon answer: one wait cycle, then answer
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else if ((read | write) & waitrequest) begin
      waitrequest <= 1'b0;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  // read data captured as waitrequest falls
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & waitrequest) begin
      unique case (address)
        OFF_CONTROL: readdata <= {24'h00_0000, 1'b0,
          control.channelSelect, state != ST_IDLE,
          control.converterEnable};
        OFF_CONFIG: readdata <= {24'h00_0000, settings[7:4], 1'b0,
          settings[2:0]};
        OFF_RES_HIGH: readdata <= {24'h00_0000, resHigh};
        OFF_RES_LOW: readdata <= {24'h00_0000, resLow};
        OFF_IRQ: readdata <= {29'h0000_0000, converterPower,
          irqEnable, doneFlag};
        default: readdata <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge clock) begin
    if (rst) begin
      control <= CONTROL_RESET;
      settings <= CONFIG_RESET;
      irqEnable <= 1'b0;
    end else begin
      if (regWrite & address == OFF_CONTROL) begin
        control.channelSelect <= writedata[6:2];
        control.converterEnable <= writedata[0];
      end
      if (regWrite & address == OFF_CONFIG) begin
        settings <= {writedata[7:4], 1'b0, writedata[2:0]};
      end
      if (regWrite & address == OFF_IRQ) begin
        irqEnable <= writedata[IRQ_ENABLE_BIT];
      end
      control.go <= (state != ST_IDLE) | startReq;
    end
  end

  // done flag: hardware set wins over a software clear
  always_ff @(posedge clock) begin
    if (rst) begin
      doneFlag <= 1'b0;
    end else if (finish) begin
      doneFlag <= 1'b1;
    end else if (regWrite & address == OFF_IRQ) begin
      doneFlag <= writedata[IRQ_FLAG_BIT];
    end
  end

  // result bytes: software may write them, conversion overwrites
  always_ff @(posedge clock) begin
    if (rst) begin
      resHigh <= 8'h00;
      resLow <= 8'h00;
    end else if (finish | (abortReq & state == ST_CONV & ~sleepAbort)) begin
      resHigh <= next_result[15:8];
      resLow <= next_result[7:0];
    end else if (regWrite) begin
      if (address == OFF_RES_HIGH) begin
        resHigh <= writedata[7:0];
      end
      if (address == OFF_RES_LOW) begin
        resLow <= writedata[7:0];
      end
    end
  end

  // ==========================================================
  // sequencer
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= ST_IDLE;
      halfCnt <= 5'd0;
      delayCnt <= 8'd0;
      sar <= 10'h000;
      bitIdx <= 4'd9;
      lastBit <= 1'b0;
      anyResolved <= 1'b0;
    end else if (abortReq | sleepAbort | finish) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (startReq) begin
            // rc clock waits one instruction so sleep can begin
            state <= isRc ? ST_DELAY : ST_CONV;
            delayCnt <= 8'(DELAY_CLKS - 1);
            halfCnt <= 5'd0;
            sar <= 10'h200;
            bitIdx <= 4'd9;
            anyResolved <= 1'b0;
          end
        end
        ST_DELAY: begin
          if (delayCnt == 8'd0) begin
            state <= ST_CONV;
          end
          delayCnt <= delayCnt - 8'd1;
        end
        ST_CONV: begin
          if (halfTick) begin
            halfCnt <= halfCnt + 5'd1;
            if (halfCnt >= SAMPLE_HALF_TADS && halfCnt[0]) begin
              sar[bitIdx] <= compareHigh;
              if (bitIdx != 4'd0) begin
                sar[bitIdx - 4'd1] <= 1'b1;
              end
              lastBit <= compareHigh;
              anyResolved <= 1'b1;
              bitIdx <= bitIdx - 4'd1;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // system clock divider, restarted each conversion
  always_ff @(posedge clock) begin
    if (rst | state != ST_CONV | halfTick) begin
      divCnt <= 6'd0;
    end else begin
      divCnt <= divCnt + 6'd1;
    end
  end

  // ==========================================================
  // sleep handling and power
  always_ff @(posedge clock) begin
    if (rst | ~sleepMode) begin
      sleepOff <= 1'b0;
    end else if (sleepAbort | (finish & ~irqEnable)) begin
      sleepOff <= 1'b1;
    end
  end

  // registered outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      converterPower <= 1'b0;
      wakeRequest <= 1'b0;
      timerReset <= 1'b0;
      sampleHold <= 1'b0;
      dacCode <= 10'h000;
      channelSelect <= 5'h00;
      channelConnected <= 1'b0;
      negRefSelect <= 1'b0;
      posRefSelect <= 2'b00;
    end else begin
      converterPower <= control.converterEnable & ~sleepOff;
      wakeRequest <= finish & sleepMode & irqEnable;
      timerReset <= specialTrigger & startReq;
      sampleHold <= state == ST_CONV & halfCnt < SAMPLE_HALF_TADS;
      dacCode <= sar;
      channelSelect <= control.channelSelect;
      // reserved codes still convert, nothing is connected
      channelConnected <= (control.channelSelect >= CH_FIRST &
        control.channelSelect <= (LARGE_VARIANT ? CH_LAST_LARGE :
        CH_LAST_SMALL)) | control.channelSelect >= CH_TEMPERATURE;
      negRefSelect <= settings.negRefSelect;
      posRefSelect <= settings.posRefSelect;
    end
  end

  // ==========================================================
  // checks
  a_finish_flags: assert property (@(posedge clock)
    disable iff (rst) finish |=> doneFlag && state == ST_IDLE)
    else $error("completion did not set flag or clear busy");
  a_abort_idle: assert property (@(posedge clock)
    disable iff (rst) (abortReq && !finish) |=> state == ST_IDLE)
    else $error("abort left sequencer running");
  a_reset_clear: assert property (@(posedge clock)
    rst |=> control == CONTROL_RESET && state == ST_IDLE)
    else $error("reset did not clear control");
  a_rc_delay: assert property (@(posedge clock)
    disable iff (rst) (startReq && isRc) |=> state == ST_DELAY)
    else $error("rc start skipped delay");
  a_wake_cause: assert property (@(posedge clock)
    disable iff (rst) wakeRequest |-> $past(irqEnable) && $past(finish))
    else $error("wake without completion");
  a_sleep_abort: assert property (@(posedge clock)
    disable iff (rst) (sleepAbort && sleepMode) |=> state == ST_IDLE ##1
    (!converterPower || !sleepMode))
    else $error("sleep did not park converter");
  a_trigger_timer: assert property (@(posedge clock)
    disable iff (rst) (specialTrigger && startReq) |=> timerReset &&
    control.go)
    else $error("trigger did not start and clear timer");
  // ten decisions leave the bit index wrapped past zero at finish
  a_conv_length: assert property (@(posedge clock)
    disable iff (rst) finish |-> halfCnt == 5'd22 && bitIdx == 4'd15)
    else $error("conversion length wrong");
  a_right_zero: assert property (@(posedge clock)
    disable iff (rst) (finish && settings.resultJustifySelect) |=>
    resHigh[7:2] == 6'h00)
    else $error("right format high bits not zero");
  a_power_off: assert property (@(posedge clock)
    disable iff (rst) !control.converterEnable |=> !converterPower)
    else $error("converter powered while disabled");
endmodule : sar_adc_conversion_control

// ---- hw/sar_ctrl_pkg.sv ----
/*
  constants, register map and carrier types for the converter control block.
  assumes a 50 MHz system clock and Avalon-MM byte addressing.
*/
package sar_ctrl_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [4:0] OFF_CONTROL = 5'h00;
  localparam logic [4:0] OFF_CONFIG = 5'h04;
  localparam logic [4:0] OFF_RES_HIGH = 5'h08;
  localparam logic [4:0] OFF_RES_LOW = 5'h0C;
  localparam logic [4:0] OFF_IRQ = 5'h10;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  // irq register bits
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_ENABLE_BIT = 1;
  localparam int IRQ_POWER_BIT = 2;
  // ==========================================================
  // field codes
  localparam logic [1:0] CLK_RC_LOW = 2'b11;
  localparam logic [4:0] CH_FIRST = 5'h04;
  localparam logic [4:0] CH_LAST_SMALL = 5'h07;
  localparam logic [4:0] CH_LAST_LARGE = 5'h0B;
  localparam logic [4:0] CH_TEMPERATURE = 5'h1D;
  localparam logic [4:0] CH_DAC = 5'h1E;
  localparam logic [4:0] CH_FIXED_REF = 5'h1F;
  localparam logic [1:0] PREF_RESERVED = 2'b01;
  // ==========================================================
  // timing: 11.5 periods counted as 23 half periods
  localparam logic [4:0] CONV_HALF_TADS = 5'd23;
  localparam logic [4:0] SAMPLE_HALF_TADS = 5'd3;
  localparam int CLK_NS = 20;
  localparam int INSTR_NS = 80;
  localparam int INSTR_CLKS = (INSTR_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic unused;
    logic [4:0] channelSelect;
    logic go;
    logic converterEnable;
  } control_t;
  typedef struct packed {
    logic resultJustifySelect;
    logic [2:0] convClockSelect;
    logic unused;
    logic negRefSelect;
    logic [1:0] posRefSelect;
  } config_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_CONV = 4'b0100,
    ST_SPARE = 4'b1000
  } state_t;
endpackage : sar_ctrl_pkg

// ---- verif/sar_adc_conversion_control_bench.sv ----
/*
  self-checking bench for the converter control block.
  assumes the package and design module compiled first; comparator is
  modelled from a bench input level against the trial code.
*/
`timescale 1ns/1ps
module sar_adc_conversion_control_bench;
  import sar_ctrl_pkg::*;
  // ==========================================================
  // signals
  logic clock = 1'b0; // system clock
  logic rst = 1'b1; // synchronous reset
  logic [4:0] address = 5'h00; // bus address
  logic read = 1'b0; // bus read strobe
  logic write = 1'b0; // bus write strobe
  logic [3:0] byteenable = 4'h1; // lane 0 only
  logic [31:0] writedata = 32'h0000_0000; // bus write data
  logic [31:0] readdata; // bus read data
  logic waitrequest; // bus stall
  logic compareHigh; // comparator model output
  logic rcTick = 1'b0; // rc half period pulse
  logic sleepMode = 1'b0; // core asleep
  logic specialTrigger = 1'b0; // trigger pulse
  logic [9:0] dacCode; // trial code
  logic sampleHold, converterPower, negRefSelect; // analog controls
  logic [4:0] channelSelect; // mux code
  logic channelConnected, wakeRequest, timerReset, doneFlag; // status
  logic [1:0] posRefSelect; // positive reference code
  logic [9:0] vin = 10'h000; // analog input as a code
  logic [31:0] rd; // last read value
  logic [2:0] tickDiv = 3'h0; // rc tick divider
  int err_count = 0; // mismatches
  int n_tests = 0; // comparisons
  // ideal comparator: a level, so it settles before each decision
  assign compareHigh = (vin >= dacCode);
  always #10 clock = ~clock;
  // rc tick every eighth clock, unrelated to bus timing
  always @(posedge clock) begin
    tickDiv <= tickDiv + 3'h1;
    rcTick <= (tickDiv == 3'h3);
  end
  sar_adc_conversion_control sar_adc_conversion_control_inst (
    .clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .compareHigh(compareHigh), .rcTick(rcTick), .sleepMode(sleepMode),
    .specialTrigger(specialTrigger), .dacCode(dacCode),
    .sampleHold(sampleHold), .converterPower(converterPower),
    .channelSelect(channelSelect), .channelConnected(channelConnected),
    .negRefSelect(negRefSelect), .posRefSelect(posRefSelect),
    .wakeRequest(wakeRequest), .timerReset(timerReset),
    .doneFlag(doneFlag));
  // ==========================================================
  // shared tasks
  task automatic complete_run;
    if (err_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= {24'h00_0000, d};
    read <= ~wr;
    write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50) begin
      chk("bus answer", 32'h0000_0000, 32'h0000_0001);
      complete_run();
    end
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus
  // wait for the done flag; also notes any wake pulse
  task automatic waitDone(output int n, output logic woke);
    n = 0;
    woke = 1'b0;
    while (doneFlag !== 1'b1 && n < 4000) begin
      @(posedge clock);
      n++;
      if (wakeRequest === 1'b1) woke = 1'b1;
    end
    repeat (2) @(posedge clock);
    if (wakeRequest === 1'b1) woke = 1'b1;
    if (n >= 4000) begin
      chk("done wait", 32'h0000_0000, 32'h0000_0001);
      complete_run();
    end
  endtask : waitDone
  // ==========================================================
  // scenarios
  task automatic t_regs;
    int c;
    bus(0, OFF_CONTROL, 8'h00);
    chk("control reset", rd, 32'h0000_0000);
    bus(0, OFF_IRQ, 8'h00);
    chk("irq reset", rd, 32'h0000_0000);
    bus(0, 5'h14, 8'h00);
    chk("unmapped", rd, 32'h0000_0000);
    bus(1, OFF_CONFIG, 8'hFF);
    bus(0, OFF_CONFIG, 8'h00);
    chk("config bit3", rd, 32'h0000_00F7);
    for (c = 0; c < 8; c++) begin
      bus(1, OFF_CONFIG, {5'h00, c[2:0]});
      @(posedge clock); // reference outputs are registered once more
      chk("negref", negRefSelect, c[2]);
      chk("posref", posRefSelect, c[1:0]);
    end
    for (c = 0; c < 32; c++) begin
      bus(1, OFF_CONTROL, {1'b0, c[4:0], 2'b01});
      @(posedge clock); // mux outputs are registered once more
      chk("channel", channelSelect, c[4:0]);
      chk("connected", channelConnected,
          (c >= 4 && c <= 11) || c >= 29);
    end
    chk("power on", converterPower, 1'b1);
    bus(1, OFF_CONTROL, 8'h80);
    @(posedge clock); // power output follows the enable a cycle later
    chk("power off", converterPower, 1'b0);
  endtask : t_regs
  // full conversion; h is the clock half period length
  task automatic t_conv(input logic [7:0] cfg, input logic [9:0] v,
                        input int h);
    int n;
    logic w;
    logic [7:0] hi;
    vin <= v;
    bus(1, OFF_CONFIG, cfg);
    bus(1, OFF_CONTROL, 8'h11);
    bus(1, OFF_CONTROL, 8'h13);
    waitDone(n, w);
    if (h > 0) chk("latency ok", n >= 23 * h - 2 && n <= 23 * h + 4,
                   1'b1);
    chk("done flag", doneFlag, 1'b1);
    chk("dac code", dacCode, v);
    bus(0, OFF_CONTROL, 8'h00);
    chk("go cleared", rd, 32'h0000_0011);
    bus(0, OFF_RES_HIGH, 8'h00);
    hi = rd[7:0];
    bus(0, OFF_RES_LOW, 8'h00);
    if (cfg[7]) begin
      chk("right", {hi, rd[7:0]}, {6'h00, v});
    end else begin
      chk("left", {hi, rd[7:0]}, {v, 6'h00});
    end
    bus(1, OFF_IRQ, 8'h00);
    chk("flag clear", doneFlag, 1'b0);
  endtask : t_conv
  task automatic t_abort;
    int k;
    logic ok;
    logic [9:0] r;
    logic [7:0] hi;
    vin <= 10'h2C5;
    bus(1, OFF_CONFIG, 8'hE0);
    bus(1, OFF_CONTROL, 8'h13);
    repeat (250) @(posedge clock);
    bus(1, OFF_CONTROL, 8'h11);
    bus(0, OFF_RES_HIGH, 8'h00);
    hi = rd[7:0];
    bus(0, OFF_RES_LOW, 8'h00);
    r = {hi[1:0], rd[7:0]};
    ok = 1'b0;
    for (k = 1; k < 10; k++) begin
      if (r == ((10'h2C5 >> (10 - k)) << (10 - k)
          | ({10{vin[10 - k]}} >> k))) ok = 1'b1;
    end
    chk("partial", ok, 1'b1);
    bus(0, OFF_CONTROL, 8'h00);
    chk("abort go", rd, 32'h0000_0011);
  endtask : t_abort
  task automatic t_sleep_abort;
    bus(1, OFF_CONFIG, 8'h60);
    bus(1, OFF_CONTROL, 8'h13);
    repeat (60) @(posedge clock);
    sleepMode <= 1'b1;
    repeat (4) @(posedge clock);
    chk("sleep power", converterPower, 1'b0);
    bus(0, OFF_CONTROL, 8'h00);
    chk("sleep ctrl", rd, 32'h0000_0011);
    chk("sleep done", doneFlag, 1'b0);
    sleepMode <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : t_sleep_abort
  task automatic t_rc_sleep(input logic ie);
    int n;
    logic w;
    bus(1, OFF_IRQ, {6'h00, ie, 1'b0});
    bus(1, OFF_CONFIG, 8'hB0);
    bus(1, OFF_CONTROL, 8'h13);
    sleepMode <= 1'b1;
    waitDone(n, w);
    chk("rc wake", w, ie);
    chk("rc power", converterPower, ie);
    bus(0, OFF_CONTROL, 8'h00);
    chk("rc enable kept", rd[0], 1'b1);
    sleepMode <= 1'b0;
    bus(1, OFF_IRQ, 8'h00);
  endtask : t_rc_sleep
  task automatic t_trig;
    int n;
    logic w, seen, held;
    seen = 1'b0;
    held = 1'b0;
    bus(1, OFF_CONFIG, 8'h80);
    specialTrigger <= 1'b1;
    @(posedge clock);
    specialTrigger <= 1'b0;
    repeat (3) begin
      @(posedge clock);
      if (timerReset === 1'b1) seen = 1'b1;
      if (sampleHold === 1'b1) held = 1'b1;
    end
    chk("timer reset", seen, 1'b1);
    chk("sample hold", held, 1'b1);
    bus(0, OFF_CONTROL, 8'h00);
    chk("trig busy", rd[1], 1'b1);
    waitDone(n, w);
    bus(1, OFF_IRQ, 8'h00);
    bus(1, OFF_CONTROL, 8'h13);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("reset power", converterPower, 1'b0);
    bus(0, OFF_CONTROL, 8'h00);
    chk("reset cancel", rd, 32'h0000_0000);
  endtask : t_trig
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_regs();
    t_conv(8'h80, 10'h2B7, 1);
    t_conv(8'h40, 10'h1C3, 2);
    t_conv(8'hD0, 10'h3FF, 8);
    t_abort();
    t_sleep_abort();
    t_rc_sleep(1'b1);
    t_rc_sleep(1'b0);
    t_trig();
    complete_run();
  end
endmodule : sar_adc_conversion_control_bench
